/* File: logic/adc_scan_pkg.sv */
// =====================================================================
// shared constants for the converter scan control
package adc_scan_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CLK_CTL = 16'h5520;
    localparam logic [15:0] IDX_DATA = 16'h5540;
    localparam logic [15:0] IDX_TRIG_CH = 16'h5542;
    localparam logic [15:0] IDX_CTL = 16'h5544;
    localparam logic [15:0] IDX_CH_STAT = 16'h5546;
    localparam logic [15:0] IDX_BUF0 = 16'h5548;
    localparam logic [15:0] IDX_BUF3 = 16'h554E;
    localparam logic [15:0] IDX_UPPER = 16'h5558;
    localparam logic [15:0] IDX_LOWER = 16'h555A;
    localparam logic [15:0] IDX_INTMASK = 16'h555C;
    localparam logic [15:0] IDX_ADVMODE = 16'h555E;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h5560;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h5562;
    // trigger/channel register fields
    localparam int END_LSB = 11;
    localparam int START_LSB = 8;
    localparam int CONT_BIT = 5;
    localparam int TS_LSB = 3;
    // control/status register fields
    localparam int CMP_EN_BIT = 15;
    localparam int CMP_CH_LSB = 12;
    localparam int ST_LSB = 8;
    localparam int IRQ_MODE_BIT = 6;
    localparam int OOR_EN_BIT = 5;
    localparam int CNV_EN_BIT = 4;
    localparam int ENABLE_BIT = 2;
    localparam int RUN_BIT = 1;
    localparam int OWE_BIT = 0;
    // clock control fields
    localparam int CLK_ON_BIT = 3;
    // mode select field
    localparam int ADV_BIT = 8;
    // trigger sources
    localparam logic [1:0] TS_SOFTWARE = 2'h0;
    localparam logic [1:0] TS_MULTI_TIMER = 2'h1;
    localparam logic [1:0] TS_EIGHT_TIMER = 2'h2;
    localparam logic [1:0] TS_EXT_PIN = 2'h3;
    // reset values
    localparam logic [1:0] ST_RESET = 2'h3;
    localparam logic CNV_EN_RESET = 1'b1;
    localparam logic [3:0] INTMASK_RESET = 4'hF;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // internal status codes
    localparam logic [1:0] ISTATE_IDLE = 2'h0;
    localparam logic [1:0] ISTATE_SAMPLE = 2'h1;
    localparam logic [1:0] ISTATE_CONVERT = 2'h3;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_RANGE = 1;
    localparam int IRQ_OVERWRITE = 2;
    // converter clocks spent converting after sampling
    localparam logic [3:0] CONV_CLOCKS = 4'hA;
endpackage : adc_scan_pkg

/* File: logic/adc_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// converter clock enable from the peripheral clock
module adc_clock_divider (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic clock_on,
    input wire logic [2:0] div_sel,
    // one-cycle enable at the divided rate
    output logic tick
);
    logic [7:0] count;
    logic [7:0] last;

    // code 0 divides by two, each step doubles
    assign last = 8'((9'h002 << div_sel) - 9'h001);

    // free counter, held clear while the clock is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (!clock_on) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count >= last) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule : adc_clock_divider
`default_nettype wire

/* File: logic/adc_scan_control.sv */
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
module adc_scan_control (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // trigger sources
    input wire logic external_trigger_pin,
    input wire logic eight_bit_timer,
    input wire logic multi_function_timer,
    // analog core
    input wire logic [9:0] analog_result,
    output logic [2:0] analog_channel,
    output logic analog_sample,
    output logic analog_convert,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT} scan_state_t;

    scan_state_t state;
    logic pend, wr_q;
    logic [15:0] idx_q;
    logic [2:0] end_ch, start_ch, current_channel, cmp_ch;
    logic continuous_mode, cmp_en, upper_limit_status, lower_limit_status;
    logic [1:0] trigger_source_sel, sample_time_sel;
    logic irq_signal_mode, oor_en, done_irq_enable, conversion_done_flag;
    logic converter_enable, run, overwrite_err, advanced_mode_sel;
    logic clock_on, tick, pin_prev, hw_trig, start_scan, conv_end, last_ch;
    logic [2:0] div_sel, irq_status, irq_mask, events;
    logic [3:0] intmask, chan_done, chan_overwrite_err, icounter;
    logic [9:0] result, upper, lower;
    logic [9:0] chan_result [4];
    logic [3:0] sample_last;
    logic [1:0] ch;
    logic wr, rd;
    logic [15:0] wd, rdmux;

    assign ch = current_channel[1:0];
    assign wr = pend && wr_q;
    assign rd = pend && !wr_q;
    assign wd = hwdata[15:0];
    // sampling lasts 2*code+3 converter clocks
    assign sample_last = 4'({sample_time_sel, 1'b0} + 3'h2);
    assign last_ch = (current_channel == end_ch);
    assign conv_end = (state == S_CONVERT) && tick
        && (icounter == adc_scan_pkg::CONV_CLOCKS - 4'h1);

    // =================================================================
    // bus slave: one wait state on every transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 16'h0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else if (pend) begin
            pend <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= wr_q ? 32'h0000_0000 : {16'h0000, rdmux};
        end else if (hsel && htrans[1] && hready) begin
            pend <= 1'b1;
            wr_q <= hwrite;
            // unmapped high bits land on an index that reads zero
            idx_q <= (haddr[31:18] == 14'h0000) ? haddr[17:2] : 16'h0000;
            hreadyout <= 1'b0;
        end
    end

    // read data mux, reserved bits zero
    always_comb begin
        rdmux = 16'h0000;
        case (idx_q)
            adc_scan_pkg::IDX_CLK_CTL: rdmux = {12'h000, clock_on, div_sel};
            adc_scan_pkg::IDX_DATA: rdmux = {6'h00, result};
            adc_scan_pkg::IDX_TRIG_CH: rdmux = {2'h0, end_ch, start_ch,
                2'h0, continuous_mode, trigger_source_sel,
                current_channel};
            adc_scan_pkg::IDX_CTL: rdmux = {cmp_en, cmp_ch,
                upper_limit_status, lower_limit_status, sample_time_sel,
                1'b0, irq_signal_mode, oor_en, done_irq_enable,
                conversion_done_flag, converter_enable, run,
                overwrite_err};
            adc_scan_pkg::IDX_CH_STAT:
                rdmux = {4'h0, chan_overwrite_err, 4'h0, chan_done};
            adc_scan_pkg::IDX_UPPER: rdmux = {6'h00, upper};
            adc_scan_pkg::IDX_LOWER: rdmux = {6'h00, lower};
            adc_scan_pkg::IDX_INTMASK: rdmux = {12'h000, intmask};
            adc_scan_pkg::IDX_ADVMODE: rdmux = {7'h00, advanced_mode_sel,
                2'h0, (state == S_IDLE) ? adc_scan_pkg::ISTATE_IDLE :
                (state == S_SAMPLE) ? adc_scan_pkg::ISTATE_SAMPLE :
                adc_scan_pkg::ISTATE_CONVERT, icounter};
            adc_scan_pkg::IDX_IRQ_STAT: rdmux = {13'h0000, irq_status};
            adc_scan_pkg::IDX_IRQ_MASK: rdmux = {13'h0000, irq_mask};
            default: begin
                if (idx_q >= adc_scan_pkg::IDX_BUF0
                        && idx_q <= adc_scan_pkg::IDX_BUF3 && !idx_q[0]) begin
                    rdmux = {6'h00, chan_result[2'(idx_q[2:1] - 2'h0)]};
                end
            end
        endcase
    end

    // =================================================================
    // software written configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_on <= 1'b0;
            div_sel <= 3'h0;
            end_ch <= 3'h0;
            start_ch <= 3'h0;
            continuous_mode <= 1'b0;
            trigger_source_sel <= adc_scan_pkg::TS_SOFTWARE;
            cmp_en <= 1'b0;
            cmp_ch <= 3'h0;
            sample_time_sel <= adc_scan_pkg::ST_RESET;
            irq_signal_mode <= 1'b0;
            oor_en <= 1'b0;
            done_irq_enable <= adc_scan_pkg::CNV_EN_RESET;
            converter_enable <= 1'b0;
            upper <= 10'h000;
            lower <= 10'h000;
            intmask <= adc_scan_pkg::INTMASK_RESET;
            advanced_mode_sel <= 1'b0;
            irq_mask <= adc_scan_pkg::IRQ_MASK_RESET;
        end else if (wr) begin
            case (idx_q)
                adc_scan_pkg::IDX_CLK_CTL: begin
                    clock_on <= wd[adc_scan_pkg::CLK_ON_BIT];
                    div_sel <= wd[2:0];
                end
                adc_scan_pkg::IDX_TRIG_CH: begin
                    end_ch <= wd[adc_scan_pkg::END_LSB +: 3];
                    start_ch <= wd[adc_scan_pkg::START_LSB +: 3];
                    continuous_mode <= wd[adc_scan_pkg::CONT_BIT];
                    trigger_source_sel <= wd[adc_scan_pkg::TS_LSB +: 2];
                end
                adc_scan_pkg::IDX_CTL: begin
                    cmp_en <= wd[adc_scan_pkg::CMP_EN_BIT];
                    cmp_ch <= wd[adc_scan_pkg::CMP_CH_LSB +: 3];
                    sample_time_sel <= wd[adc_scan_pkg::ST_LSB +: 2];
                    irq_signal_mode <= wd[adc_scan_pkg::IRQ_MODE_BIT];
                    oor_en <= wd[adc_scan_pkg::OOR_EN_BIT];
                    if (advanced_mode_sel) begin
                        done_irq_enable <= wd[adc_scan_pkg::CNV_EN_BIT];
                    end
                    converter_enable <= wd[adc_scan_pkg::ENABLE_BIT];
                end
                adc_scan_pkg::IDX_UPPER: upper <= wd[9:0];
                adc_scan_pkg::IDX_LOWER: lower <= wd[9:0];
                adc_scan_pkg::IDX_INTMASK: intmask <= wd[3:0];
                adc_scan_pkg::IDX_ADVMODE:
                    advanced_mode_sel <= wd[adc_scan_pkg::ADV_BIT];
                adc_scan_pkg::IDX_IRQ_MASK: irq_mask <= wd[2:0];
                default: ;
            endcase
        end
    end

    // =================================================================
    // converter clock enable
    adc_clock_divider u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clock_on(clock_on),
        .div_sel(div_sel),
        .tick(tick)
    );

    // =================================================================
    // trigger selection, pin taken on its rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= external_trigger_pin;
        end
    end

    always_comb begin
        case (trigger_source_sel)
            adc_scan_pkg::TS_EXT_PIN: hw_trig = external_trigger_pin
                && !pin_prev;
            adc_scan_pkg::TS_EIGHT_TIMER: hw_trig = eight_bit_timer;
            adc_scan_pkg::TS_MULTI_TIMER: hw_trig = multi_function_timer;
            default: hw_trig = 1'b1;
        endcase
    end

    assign start_scan = (state == S_IDLE) && run && converter_enable
        && hw_trig;

    // run bit: software sets and stops, a single pass ends it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= 1'b0;
        end else if (wr && idx_q == adc_scan_pkg::IDX_CTL) begin
            run <= wd[adc_scan_pkg::RUN_BIT];
        end else if (conv_end && last_ch && !continuous_mode) begin
            run <= 1'b0;
        end else if (!converter_enable) begin
            run <= 1'b0;
        end
    end

    // =================================================================
    // scan sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
            current_channel <= 3'h0;
            icounter <= 4'h0;
            analog_sample <= 1'b0;
            analog_convert <= 1'b0;
        end else if (state != S_IDLE && !run) begin
            state <= S_IDLE;
            analog_sample <= 1'b0;
            analog_convert <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start_scan) begin
                        state <= S_SAMPLE;
                        current_channel <= start_ch;
                        icounter <= 4'h0;
                        analog_sample <= 1'b1;
                    end
                end
                S_SAMPLE: begin
                    if (tick && icounter == sample_last) begin
                        state <= S_CONVERT;
                        icounter <= 4'h0;
                        analog_sample <= 1'b0;
                        analog_convert <= 1'b1;
                    end else if (tick) begin
                        icounter <= icounter + 4'h1;
                    end
                end
                S_CONVERT: begin
                    if (conv_end) begin
                        icounter <= 4'h0;
                        analog_convert <= 1'b0;
                        if (!last_ch) begin
                            state <= S_SAMPLE;
                            current_channel <= current_channel + 3'h1;
                            analog_sample <= 1'b1;
                        end else if (continuous_mode) begin
                            state <= S_SAMPLE;
                            current_channel <= start_ch;
                            analog_sample <= 1'b1;
                        end else begin
                            state <= S_IDLE;
                        end
                    end else if (tick) begin
                        icounter <= icounter + 4'h1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // =================================================================
    // standard result, done and overwrite flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result <= 10'h000;
            conversion_done_flag <= 1'b0;
            overwrite_err <= 1'b0;
        end else begin
            if (conv_end) begin
                result <= analog_result;
            end
            conversion_done_flag <= conv_end
                || (conversion_done_flag
                && !(rd && idx_q == adc_scan_pkg::IDX_DATA));
            // set wins over a clearing write
            overwrite_err <= (conv_end && conversion_done_flag)
                || (overwrite_err && !(wr && idx_q == adc_scan_pkg::IDX_CTL
                && !wd[adc_scan_pkg::OWE_BIT]));
        end
    end

    // per-channel buffers and flags
    for (genvar i = 0; i < 4; i++) begin : g_chan
        logic hit;
        assign hit = conv_end && advanced_mode_sel && ch == 2'(i);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                chan_result[i] <= 10'h000;
                chan_done[i] <= 1'b0;
                chan_overwrite_err[i] <= 1'b0;
            end else begin
                if (hit) begin
                    chan_result[i] <= analog_result;
                end
                chan_done[i] <= hit || (chan_done[i] && !(rd
                    && idx_q == adc_scan_pkg::IDX_BUF0 + 16'(2 * i)));
                chan_overwrite_err[i] <= (hit && chan_done[i])
                    || (chan_overwrite_err[i] && !(wr
                    && idx_q == adc_scan_pkg::IDX_CH_STAT && !wd[8 + i]));
            end
        end
    end

    // limit comparison on the chosen channel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_limit_status <= 1'b0;
            lower_limit_status <= 1'b0;
        end else if (conv_end && advanced_mode_sel && cmp_en
                && current_channel == cmp_ch) begin
            upper_limit_status <= analog_result > upper;
            lower_limit_status <= analog_result < lower;
        end
    end

    // =================================================================
    // interrupt status, mask and output
    assign events[adc_scan_pkg::IRQ_DONE] = conv_end && done_irq_enable
        && (!advanced_mode_sel || intmask[ch])
        && !(advanced_mode_sel && irq_signal_mode && !last_ch);
    assign events[adc_scan_pkg::IRQ_RANGE] = conv_end && advanced_mode_sel
        && cmp_en && oor_en && current_channel == cmp_ch
        && (analog_result > upper || analog_result < lower);
    assign events[adc_scan_pkg::IRQ_OVERWRITE] = conv_end
        && (advanced_mode_sel ? chan_done[ch] : conversion_done_flag);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= events | (irq_status & ~((wr
                && idx_q == adc_scan_pkg::IDX_IRQ_STAT) ? wd[2:0] : 3'h0));
            irq <= |(irq_status & irq_mask);
        end
    end

    assign analog_channel = current_channel;

    // =================================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_end_field: assert property (wr && idx_q == adc_scan_pkg::IDX_TRIG_CH
        |=> end_ch == $past(hwdata[13:11])) else $error("end channel lost");
    chk_start_field: assert property (wr && idx_q == adc_scan_pkg::IDX_TRIG_CH
        |=> start_ch == $past(hwdata[10:8])) else $error("start channel lost");
    chk_repeat_scan: assert property (conv_end && last_ch && continuous_mode
        && run |=> state == S_SAMPLE && current_channel == start_ch)
        else $error("continuous scan did not restart");
    chk_single_stop: assert property (conv_end && last_ch && !continuous_mode
        && !wr |=> state == S_IDLE && !run) else $error("single scan ran on");
    chk_sw_start: assert property (start_scan
        |=> state == S_SAMPLE && current_channel == $past(start_ch))
        else $error("trigger did not start scan");
    chk_chan_status: assert property (rd && idx_q == adc_scan_pkg::IDX_TRIG_CH
        |=> hrdata[2:0] == $past(current_channel))
        else $error("channel status wrong");
    chk_sample_len: assert property ($rose(analog_sample) && state == S_SAMPLE
        |-> !analog_convert throughout (state == S_SAMPLE))
        else $error("convert during sampling");
    chk_overwrite_set: assert property (conv_end && conversion_done_flag
        |=> overwrite_err) else $error("overwrite not flagged");
    chk_limit_cmp: assert property (conv_end && advanced_mode_sel && cmp_en
        && current_channel == cmp_ch
        |=> upper_limit_status == ($past(analog_result) > upper))
        else $error("upper compare wrong");
    chk_buffer_store: assert property (conv_end && advanced_mode_sel
        |=> chan_result[$past(ch)] == $past(analog_result))
        else $error("buffer not stored");
    chk_mask_gate: assert property (conv_end && advanced_mode_sel
        && !intmask[ch] && !irq_status[0] && !wr |=> !irq_status[0])
        else $error("masked channel raised done");
    chk_clock_gate: assert property (!clock_on [*2] |-> !tick)
        else $error("tick while clock off");

    cov_wrap: cover property (conv_end && last_ch && continuous_mode);
    cov_overwrite: cover property (overwrite_err);
    cov_range: cover property (events[adc_scan_pkg::IRQ_RANGE]);
    cov_irq: cover property ($rose(irq));
endmodule : adc_scan_control
`default_nettype wire

/* File: verification/analog_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// analog core: result tracks the channel while converting
module analog_core_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // converter side
    input wire logic analog_convert,
    input wire logic [2:0] analog_channel,
    output logic [9:0] analog_result
);
    // result valid only while converting, else a toggling pattern
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_result <= 10'h3C3;
        end else if (analog_convert) begin
            analog_result <= {7'h55, analog_channel};
        end else begin
            analog_result <= ~analog_result;
        end
    end
endmodule : analog_core_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// self-checking bench for the scan control block
module testbench;
    logic hclk, hresetn, hwrite, irq, hreadyout, conv, trg;
    logic [1:0] htrans;
    logic [2:0] ch;
    logic [9:0] res;
    logic [31:0] haddr, hwdata, hrdata, d;
    int miscompares = 0, checks = 0, cycles = 0;

    // =================================================================
    // design and partner
    adc_scan_control i_adc_scan_control (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .external_trigger_pin(trg), .eight_bit_timer(trg),
        .multi_function_timer(trg), .analog_result(res),
        .analog_channel(ch), .analog_sample(), .analog_convert(conv),
        .irq(irq));
    analog_core_model i_analog_core_model (.hclk(hclk), .hresetn(hresetn),
        .analog_convert(conv), .analog_channel(ch), .analog_result(res));

    // =================================================================
    // bus tasks
    task automatic wait_rdy(output logic [31:0] rd);
        // ready and read data taken at the same rising edge
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : wait_rdy
    task automatic xfer(input logic [15:0] idx, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        haddr <= {14'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
            miscompares++;
        end
    endtask : chk
    task automatic wr(input logic [15:0] idx, input logic [31:0] v);
        xfer(idx, 1'b1, v, d);
    endtask : wr
    task automatic rc(input logic [15:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0, d);
        chk(d, exp);
    endtask : rc
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // =================================================================
    // clock, reset and timeout
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    // =================================================================
    // tests
    initial begin
        hresetn = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        trg = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(adc_scan_pkg::IDX_TRIG_CH, 32'h0);
        rc(adc_scan_pkg::IDX_CTL, 32'h310);
        rc(adc_scan_pkg::IDX_INTMASK, 32'hF);
        rc(16'h0100, 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            wr(adc_scan_pkg::IDX_TRIG_CH, 32'h1927 | (k << 3));
            rc(adc_scan_pkg::IDX_TRIG_CH, 32'h1920 | (k << 3));
            wr(adc_scan_pkg::IDX_CTL, k << 8);
            rc(adc_scan_pkg::IDX_CTL, 32'h10 | (k << 8));
        end
        $display("test field access done");
        wr(adc_scan_pkg::IDX_CLK_CTL, 32'h8);
        wr(adc_scan_pkg::IDX_IRQ_MASK, 32'h1);
        wr(adc_scan_pkg::IDX_TRIG_CH, 32'h0800);
        wr(adc_scan_pkg::IDX_CTL, 32'h16);
        // single pass ends by clearing run
        do xfer(adc_scan_pkg::IDX_CTL, 1'b0, 32'h0, d); while (d[1] !== 1'b0);
        rc(adc_scan_pkg::IDX_TRIG_CH, 32'h0801);
        rc(adc_scan_pkg::IDX_CTL, 32'h1D);
        chk({31'h0, irq}, 32'h1);
        rc(adc_scan_pkg::IDX_DATA, 32'h2A9);
        wr(adc_scan_pkg::IDX_CTL, 32'h14);
        rc(adc_scan_pkg::IDX_CTL, 32'h14);
        wr(adc_scan_pkg::IDX_IRQ_STAT, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        $display("test scan done");
        // hardware sources: no start until the selected source fires
        for (int k = 1; k < 4; k++) begin
            wr(adc_scan_pkg::IDX_TRIG_CH, k << 3);
            wr(adc_scan_pkg::IDX_CTL, 32'h16);
            rc(adc_scan_pkg::IDX_ADVMODE, 32'h0);
            trg <= 1'b1;
            @(posedge hclk);
            trg <= 1'b0;
            do xfer(adc_scan_pkg::IDX_CTL, 1'b0, 32'h0, d);
            while (d[1] !== 1'b0);
            rc(adc_scan_pkg::IDX_DATA, 32'h2A8);
        end
        $display("test trigger sources done");
        // continuous scan keeps run set until software stops it
        wr(adc_scan_pkg::IDX_TRIG_CH, 32'h0020);
        wr(adc_scan_pkg::IDX_CTL, 32'h16);
        repeat (100) @(posedge hclk);
        xfer(adc_scan_pkg::IDX_CTL, 1'b0, 32'h0, d);
        chk({31'h0, d[1]}, 32'h1);
        wr(adc_scan_pkg::IDX_CTL, 32'h14);
        xfer(adc_scan_pkg::IDX_ADVMODE, 1'b0, 32'h0, d);
        chk({30'h0, d[5:4]}, 32'h0);
        $display("test continuous done");
        // advanced: buffers, limit compare on channel 1, done masked
        wr(adc_scan_pkg::IDX_IRQ_STAT, 32'h7);
        wr(adc_scan_pkg::IDX_ADVMODE, 32'h100);
        wr(adc_scan_pkg::IDX_UPPER, 32'h2A8);
        wr(adc_scan_pkg::IDX_INTMASK, 32'h0);
        wr(adc_scan_pkg::IDX_TRIG_CH, 32'h0800);
        wr(adc_scan_pkg::IDX_CTL, 32'h9036);
        do xfer(adc_scan_pkg::IDX_CTL, 1'b0, 32'h0, d); while (d[1] !== 1'b0);
        chk(d, 32'h983D);
        rc(adc_scan_pkg::IDX_IRQ_STAT, 32'h2);
        rc(adc_scan_pkg::IDX_CH_STAT, 32'h3);
        rc(adc_scan_pkg::IDX_BUF0, 32'h2A8);
        rc(adc_scan_pkg::IDX_BUF0 + 16'h2, 32'h2A9);
        $display("test advanced done");
        results();
    end
endmodule : testbench
`default_nettype wire
